// ### hdl/spc_pkg.sv
// Package for the slot access permission checker: register map, fields and encodings.
package spc_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the Avalon-MM slave)
    // ------------------------------------------------------------
    localparam int unsigned         ADDR_W          = 9;
    localparam logic [8:0]          ADDR_REQ        = 9'h000;
    localparam logic [8:0]          ADDR_RESULT     = 9'h004;
    localparam logic [8:0]          ADDR_OTP_POLICY = 9'h008;
    localparam logic [8:0]          ADDR_DENY_CNT   = 9'h00c;
    localparam logic [8:0]          ADDR_SLOT_BASE  = 9'h080;
    localparam logic [6:0]          IDX_DATA_LOCK   = 7'h56;
    localparam logic [6:0]          IDX_CFG_LOCK    = 7'h57;
    localparam logic [8:0]          ADDR_DATA_LOCK  = {IDX_DATA_LOCK, 2'b00};
    localparam logic [8:0]          ADDR_CFG_LOCK   = {IDX_CFG_LOCK, 2'b00};

    // ------------------------------------------------------------
    // Lock values, sizes and policy encodings
    // ------------------------------------------------------------
    localparam logic [7:0]          LOCK_OPEN       = 8'h55;
    localparam logic [7:0]          LOCK_SHUT       = 8'h00;
    localparam logic [7:0]          OTP_READ_ONLY   = 8'haa;
    localparam int unsigned         NUM_SLOTS       = 16;
    localparam logic [6:0]          CFG_FIXED_LAST  = 7'd12;
    localparam logic [6:0]          CFG_DATA_LOCK   = 7'd86;
    localparam logic [6:0]          CFG_CFG_LOCK    = 7'd87;
    localparam logic [1:0]          HASH_ID_FIXED   = 2'b01;
    localparam logic [1:0]          HASH_ID_DIE     = 2'b10;

    // Bit positions inside a slot policy word.
    localparam int unsigned         SP_READ_KEY_LO  = 0;
    localparam int unsigned         SP_ENC_READ     = 6;
    localparam int unsigned         SP_SECRET       = 7;
    localparam int unsigned         SP_WRITE_KEY_LO = 8;
    localparam int unsigned         SP_WP_CREATE    = 12;
    localparam int unsigned         SP_WP_DERIVE    = 13;
    localparam int unsigned         SP_WP_ENCRYPT   = 14;
    localparam int unsigned         SP_WP_AUTH      = 15;

    typedef enum logic [1:0] {
        SPC_OP_READ,
        SPC_OP_WRITE,
        SPC_OP_DERIVE,
        SPC_OP_LOCK
    } spc_op_t;

    typedef enum logic [1:0] {
        SPC_ZONE_CFG,
        SPC_ZONE_OTP,
        SPC_ZONE_DATA,
        SPC_ZONE_RSVD
    } spc_zone_t;

    // Request word as written to ADDR_REQ (bits 22:0).
    typedef struct packed {
        logic [6:0] cfg_addr;
        logic [4:0] pad;
        logic       per_die;
        logic       mac_ok;
        logic       size32;
        logic [3:0] slot;
        spc_zone_t  zone;
        spc_op_t    op;
    } spc_req_t;

    // Result word as read from ADDR_RESULT (bits 18:0).
    typedef struct packed {
        logic [7:0] seq;
        logic [1:0] hash_id;
        logic [3:0] key_slot;
        logic       mac_used;
        logic       encrypt;
        logic       error;
        logic       allow;
        logic       done;
    } spc_result_t;

endpackage

// ### hdl/spc_checker.sv
// Slot access permission checker with its Avalon-MM register slave.
//
// Operation
// - Public slot: clear reads, 4 or 32 bytes.
// - Secret, not encrypted: reads always refused.
// - Secret and encrypted: encrypted 32-byte reads only.
// - Always-write code: clear writes, 4 or 32.
// - Never-write codes refuse all writes.
// - Encrypt code: MAC, encrypted, 32-byte writes only.
// - Derive bit 12 picks target or parent key.
// - Derive needs MAC when bit 15 set.
// - Derive refused when bit 13 clear.
// - Write and derive meanings apply together.
// - Secret slots refuse 4-byte reads and writes.
// - Config bytes 0..12 readable, never writable.
// - Fixed id bytes always hashed, die bytes optional.
// - Locks change only by lock, never unlock.
// - Data/OTP access refused before config lock.
// - Only 0x55 means unlocked.
// - Config writable only while config unlocked.
// - Data unlocked: no reads, writes allowed.
// - OTP between locks: writes allowed, reads refused.
// - Read-only OTP: writes error, reads allowed.
// - Self-keyed encrypt slot accepts MAC writes.
// - Lock command turns 0x55 into 0x00.
// - Data unlocked: slot policies do not apply.
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
`default_nettype none

module spc_checker (
    input  wire logic                 i_core_clk,    // Core clock, 100 MHz.
    input  wire logic                 i_sys_rst,     // Synchronous reset, active high.
    input  wire logic [8:0]           i_address,     // Avalon byte address.
    input  wire logic                 i_read,        // Avalon read request.
    input  wire logic                 i_write,       // Avalon write request.
    input  wire logic [31:0]          i_writedata,   // Avalon write data.
    input  wire logic [3:0]           i_byteenable,  // Avalon byte enables.
    output logic [31:0]               o_readdata,    // Avalon read data.
    output logic                      o_waitrequest, // Avalon wait request.
    output spc_pkg::spc_result_t      o_result       // Last permission verdict.
);
    import spc_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic                                 wait_n;
        logic [31:0]                          rdata;
        logic [7:0]                           lock_cfg;
        logic [7:0]                           lock_dat;
        logic [7:0]                           otp_pol;
        logic [15:0]                          deny_cnt;
        logic [NUM_SLOTS-1:0][15:0]           slot_pol;
        spc_result_t                          res;
    } spc_state_t;

    localparam spc_state_t ST_RESET = '{
        wait_n:   1'b0,
        rdata:    32'h0000_0000,
        lock_cfg: LOCK_OPEN,
        lock_dat: LOCK_OPEN,
        otp_pol:  OTP_READ_ONLY,
        deny_cnt: 16'h0000,
        slot_pol: '0,
        res:      '0
    };

    spc_state_t st_q;
    spc_state_t st_d;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic        acc;
    logic        wr_acc;
    logic        rd_acc;
    logic        slot_hit;
    logic [3:0]  slot_idx;
    logic        cfg_unl;
    logic        dat_unl;
    spc_req_t    req;
    logic [15:0] pol;
    logic [3:0]  wp;

    // Seen while waitrequest is high, acked next cycle; read data is latched when seen.
    assign acc      = (i_read || i_write) && st_q.wait_n;
    assign wr_acc   = acc && i_write;
    assign rd_acc   = i_read && !st_q.wait_n;
    assign slot_hit = (i_address[8:6] == ADDR_SLOT_BASE[8:6]);
    assign slot_idx = i_address[5:2];
    assign cfg_unl  = (st_q.lock_cfg == LOCK_OPEN);
    assign dat_unl  = (st_q.lock_dat == LOCK_OPEN);
    assign req      = spc_req_t'(i_writedata[22:0]);
    assign pol      = st_q.slot_pol[req.slot];
    assign wp       = pol[SP_WP_AUTH:SP_WP_CREATE];

    // Byte-lane merge so partial writes leave the other lanes alone.
    function automatic logic [31:0] merge(input logic [31:0] old_v,
                                          input logic [31:0] new_v,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // ------------------------------------------------------------
    // Permission decision for the request word.
    // ------------------------------------------------------------
    spc_result_t vd;

    always_comb begin
        vd          = '0;
        vd.done     = 1'b1;
        vd.seq      = 8'(st_q.res.seq + 8'h01);
        vd.hash_id  = HASH_ID_FIXED | (req.per_die ? HASH_ID_DIE : 2'b00);
        case (req.op)
            SPC_OP_READ: begin
                case (req.zone)
                    SPC_ZONE_CFG: begin
                        vd.allow = 1'b1;
                    end
                    SPC_ZONE_OTP: begin
                        // Unlocked OTP cannot be read; read-only mode allows 4 or 32.
                        vd.allow = !cfg_unl && !dat_unl
                                   && (st_q.otp_pol == OTP_READ_ONLY);
                    end
                    SPC_ZONE_DATA: begin
                        if (cfg_unl || dat_unl) begin
                            vd.allow = 1'b0;
                        end else if (!pol[SP_SECRET]) begin
                            // The public-but-encrypted code is prohibited; treat it as denied.
                            vd.allow = !pol[SP_ENC_READ];
                        end else if (pol[SP_ENC_READ]) begin
                            vd.allow    = req.size32;
                            vd.encrypt  = 1'b1;
                            vd.key_slot = pol[SP_READ_KEY_LO +: 4];
                        end else begin
                            vd.allow = 1'b0;
                        end
                    end
                    default: begin
                        vd.allow = 1'b0;
                    end
                endcase
            end
            SPC_OP_WRITE: begin
                case (req.zone)
                    SPC_ZONE_CFG: begin
                        // Fixed id bytes and both lock bytes are never writable here.
                        vd.allow = cfg_unl && (req.cfg_addr > CFG_FIXED_LAST)
                                   && (req.cfg_addr != CFG_DATA_LOCK)
                                   && (req.cfg_addr != CFG_CFG_LOCK);
                    end
                    SPC_ZONE_OTP: begin
                        vd.allow = !cfg_unl && dat_unl;
                    end
                    SPC_ZONE_DATA: begin
                        if (cfg_unl) begin
                            vd.allow = 1'b0;
                        end else if (dat_unl) begin
                            vd.allow = 1'b1;
                        end else if (wp[SP_WP_ENCRYPT - SP_WP_CREATE]) begin
                            // Self-keyed slots roll their secret through this same path.
                            vd.allow    = req.size32 && req.mac_ok;
                            vd.encrypt  = 1'b1;
                            vd.mac_used = 1'b1;
                            vd.key_slot = pol[SP_WRITE_KEY_LO +: 4];
                        end else if (wp[3:1] == 3'b000) begin
                            vd.allow = req.size32 || !pol[SP_SECRET];
                        end else begin
                            vd.allow = 1'b0;
                        end
                    end
                    default: begin
                        vd.allow = 1'b0;
                    end
                endcase
            end
            SPC_OP_DERIVE: begin
                // Keys are only derived once personalisation is locked down.
                vd.mac_used = wp[SP_WP_AUTH - SP_WP_CREATE];
                vd.key_slot = wp[0] ? pol[SP_WRITE_KEY_LO +: 4] : req.slot;
                vd.allow    = (req.zone == SPC_ZONE_DATA) && !cfg_unl && !dat_unl
                              && wp[SP_WP_DERIVE - SP_WP_CREATE]
                              && (!vd.mac_used || req.mac_ok);
            end
            SPC_OP_LOCK: begin
                if (req.zone == SPC_ZONE_CFG) begin
                    vd.allow = cfg_unl;
                end else begin
                    vd.allow = !cfg_unl && dat_unl && (req.zone != SPC_ZONE_RSVD);
                end
            end
            default: begin
                vd.allow = 1'b0;
            end
        endcase
        vd.error = !vd.allow;
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        st_d        = st_q;
        st_d.wait_n = (i_read || i_write) && !st_q.wait_n;
        if (rd_acc) begin
            st_d.rdata = 32'h0000_0000;
            if (slot_hit) begin
                st_d.rdata = {16'h0000, st_q.slot_pol[slot_idx]};
            end else begin
                case (i_address)
                    ADDR_RESULT:     st_d.rdata = 32'(st_q.res);
                    ADDR_OTP_POLICY: st_d.rdata = {24'h000000, st_q.otp_pol};
                    ADDR_DENY_CNT:   st_d.rdata = {16'h0000, st_q.deny_cnt};
                    ADDR_DATA_LOCK:  st_d.rdata = {24'h000000, st_q.lock_dat};
                    ADDR_CFG_LOCK:   st_d.rdata = {24'h000000, st_q.lock_cfg};
                    default:         st_d.rdata = 32'h0000_0000;
                endcase
            end
        end
        if (wr_acc) begin
            // Policy bytes live in the configuration zone and freeze with it.
            if (slot_hit && cfg_unl) begin
                st_d.slot_pol[slot_idx] = 16'(merge({16'h0000, st_q.slot_pol[slot_idx]},
                                                    i_writedata, i_byteenable));
            end
            if ((i_address == ADDR_OTP_POLICY) && cfg_unl) begin
                st_d.otp_pol = 8'(merge({24'h000000, st_q.otp_pol},
                                        i_writedata, i_byteenable));
            end
            if (i_address == ADDR_REQ) begin
                st_d.res = vd;
                if (!vd.allow) begin
                    st_d.deny_cnt = 16'(st_q.deny_cnt + 16'h0001);
                end
                // Lock bytes move only one way, and only on a granted lock.
                if (vd.allow && (req.op == SPC_OP_LOCK)) begin
                    if (req.zone == SPC_ZONE_CFG) begin
                        st_d.lock_cfg = LOCK_SHUT;
                    end else begin
                        st_d.lock_dat = LOCK_SHUT;
                    end
                end
            end
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (i_sys_rst) begin
            st_q <= ST_RESET;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_readdata    = st_q.rdata;
    assign o_waitrequest = !st_q.wait_n;
    assign o_result      = st_q.res;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_sys_rst);

    logic chk;
    assign chk = wr_acc && (i_address == ADDR_REQ);

    a_ack_one_cycle: assert property ((i_read || i_write) && !o_waitrequest |=> o_waitrequest)
        else $error("Wait request dropped for more than one cycle.");
    a_cfg_lock_stays: assert property (
        st_q.lock_cfg != LOCK_OPEN |=> st_q.lock_cfg == $past(st_q.lock_cfg))
        else $error("Config lock byte changed after locking.");
    a_lock_to_zero: assert property (
        chk && req.op == SPC_OP_LOCK && req.zone == SPC_ZONE_CFG && cfg_unl
        |=> st_q.lock_cfg == LOCK_SHUT)
        else $error("Config lock did not become zero.");
    a_pre_cfg_deny: assert property (
        chk && cfg_unl && req.zone != SPC_ZONE_CFG && req.op != SPC_OP_LOCK |=> o_result.error)
        else $error("Data or OTP access granted before config lock.");
    a_fixed_id_ro: assert property (
        chk && req.op == SPC_OP_WRITE && req.zone == SPC_ZONE_CFG
        && req.cfg_addr <= CFG_FIXED_LAST |=> o_result.error ##1 o_result.error)
        else $error("Fixed id byte write granted.");
    a_secret_short: assert property (
        chk && !cfg_unl && !dat_unl && req.zone == SPC_ZONE_DATA && req.op != SPC_OP_DERIVE
        && pol[SP_SECRET] && !req.size32 |=> o_result.error)
        else $error("Short access to secret slot granted.");
    a_no_derive: assert property (
        chk && req.op == SPC_OP_DERIVE && !pol[SP_WP_DERIVE] |=> !o_result.allow)
        else $error("Derive granted on ineligible target.");
    a_derive_src: assert property (
        chk && req.op == SPC_OP_DERIVE && pol[SP_WP_DERIVE] && !pol[SP_WP_CREATE]
        |=> o_result.key_slot == $past(req.slot))
        else $error("Roll derive used wrong key slot.");
    a_unlocked_read: assert property (
        chk && !cfg_unl && dat_unl && req.op == SPC_OP_READ && req.zone != SPC_ZONE_CFG
        |=> o_result.error)
        else $error("Read granted while data zone unlocked.");
    a_deny_counted: assert property (
        chk && vd.error |=> st_q.deny_cnt == 16'($past(st_q.deny_cnt) + 16'h0001))
        else $error("Denied check not counted.");

    c_cfg_lock:  cover property (chk && req.op == SPC_OP_LOCK && cfg_unl ##1 !cfg_unl);
    c_enc_write: cover property (chk && vd.allow && vd.encrypt && req.op == SPC_OP_WRITE);
    c_derive:    cover property (chk && vd.allow && req.op == SPC_OP_DERIVE);
    c_otp_read:  cover property (chk && vd.allow && req.zone == SPC_ZONE_OTP
                                 && req.op == SPC_OP_READ);

endmodule

`default_nettype wire

// ### dv/spc_host_model.sv
// Host bus model that issues Avalon-MM register and command traffic.
`timescale 1ns/100ps
`default_nettype none

module spc_host_model (
    input  wire logic        i_core_clk,    // Core clock.
    input  wire logic [31:0] i_readdata,    // Read data.
    input  wire logic        i_waitrequest, // Slave stall.
    output logic [8:0]       o_address,     // Byte address.
    output logic             o_read,        // Read request.
    output logic             o_write,       // Write request.
    output logic [31:0]      o_writedata,   // Write data.
    output logic [3:0]       o_byteenable   // Byte lanes.
);
    // ------------------------------------------------------------
    // Bus cycles
    // ------------------------------------------------------------
    // Idle at time zero so the slave never sees an unknown request.
    initial begin
        o_address    = 9'h000;
        o_read       = 1'b0;
        o_write      = 1'b0;
        o_writedata  = 32'h0000_0000;
        o_byteenable = 4'hf;
    end

    // Holds the request until waitrequest is sampled low; released address and data
    // lines are inverted so that a stale address or data word can never pass for a live one.
    task automatic cycle(input logic rw, input logic [8:0] a, input logic [31:0] d,
                         output logic [31:0] q);
        repeat ($urandom_range(0, 2)) @(posedge i_core_clk);
        @(posedge i_core_clk);
        o_address   <= a;
        o_writedata <= d;
        o_write     <= rw;
        o_read      <= !rw;
        do @(posedge i_core_clk); while (i_waitrequest !== 1'b0);
        q = i_readdata;
        o_write     <= 1'b0;
        o_read      <= 1'b0;
        o_address   <= ~a;
        o_writedata <= ~d;
    endtask

    // Keeps slot policies legal on the host side.
    function automatic logic [15:0] legal(input logic [15:0] p);
        logic [15:0] q;
        q = p;
        if (q[15:13] != 3'b000) q[7] = 1'b1;
        if (!q[7]) q[6] = 1'b0;
        return q;
    endfunction
endmodule

`default_nettype wire

// ### dv/spc_checker_tb.sv
// Self-checking testbench for the slot access permission checker.
`timescale 1ns/100ps
`default_nettype none

module spc_checker_tb;
    import spc_pkg::*;

    // One expected verdict; the chk flags say which extra fields count.
    typedef struct packed {
        logic       allow;
        logic       key_chk;
        logic [3:0] key;
        logic       hash_chk;
        logic [1:0] hash;
        logic       enc_chk;
        logic       enc;
    } spc_note_t;

    localparam logic [3:0] EARLY [6] = '{4'h4, 4'h5, 4'h8, 4'h9, 4'ha, 4'hb};
    localparam logic [6:0] EDGE  [5] = '{7'd0, 7'd12, 7'd13, 7'd86, 7'd87};

    logic        i_core_clk = 1'b0;
    logic        i_sys_rst  = 1'b1;
    logic [8:0]  av_addr;
    logic        av_rd;
    logic        av_wr;
    logic [31:0] av_wdata;
    logic [3:0]  av_be;
    logic [31:0] av_rdata;
    logic        av_wait;
    spc_result_t result;
    spc_note_t   notes[$];
    spc_note_t   note;
    spc_note_t   seen;
    logic [15:0] pol [NUM_SLOTS];
    logic [31:0] rdata;
    logic [7:0]  last_seq = 8'h00;
    int          bad_count = 0;
    int          total_checks = 0;
    int          denies = 0;

    // ------------------------------------------------------------
    // Clock, design and host
    // ------------------------------------------------------------
    // Free-running 100 MHz clock.
    always #5 i_core_clk = ~i_core_clk;

    spc_checker dut_u (
        .i_core_clk    (i_core_clk),
        .i_sys_rst     (i_sys_rst),
        .i_address     (av_addr),
        .i_read        (av_rd),
        .i_write       (av_wr),
        .i_writedata   (av_wdata),
        .i_byteenable  (av_be),
        .o_readdata    (av_rdata),
        .o_waitrequest (av_wait),
        .o_result      (result)
    );

    spc_host_model host_u (
        .i_core_clk    (i_core_clk),
        .i_readdata    (av_rdata),
        .i_waitrequest (av_wait),
        .o_address     (av_addr),
        .o_read        (av_rd),
        .o_write       (av_wr),
        .o_writedata   (av_wdata),
        .o_byteenable  (av_be)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic rchk(input string n, input logic [8:0] a, input logic [31:0] m,
                        input logic [31:0] e);
        host_u.cycle(1'b0, a, 32'h0, rdata);
        check(n, rdata & m, e);
    endtask

    function automatic spc_note_t nt(input logic a);
        return {a, 10'h000};
    endfunction

    // Notes the expected verdict first, then writes the request word.
    task automatic req(input logic [3:0] oz, input logic [3:0] sl, input logic sz,
                       input logic mac, input logic [6:0] ca, input spc_note_t n);
        notes.push_back(n);
        if (!n.allow) denies++;
        host_u.cycle(1'b1, ADDR_REQ, {9'h000, ca, 5'h00, n.hash[1], mac, sz, sl, oz}, rdata);
    endtask

    // Config bytes: fixed and lock bytes are never writable, the rest only while open.
    task automatic cfg_sweep(input logic open);
        logic [6:0] a;
        for (int i = 0; i < 8; i++) begin
            a = (i < 5) ? EDGE[i] : 7'($urandom_range(13, 85));
            req(4'h0, 4'h0, 1'b0, 1'b0, a, nt(1'b1));
            req(4'h1, 4'h0, 1'b0, 1'b0, a, nt(open && a > CFG_FIXED_LAST &&
                a != CFG_DATA_LOCK && a != CFG_CFG_LOCK));
        end
    endtask

    // Verdict for a data-zone request once both zones are locked.
    function automatic spc_note_t exp_data(input logic [15:0] p, input logic [3:0] s,
                                           input int op, input logic sz, input logic mac,
                                           input logic pd);
        spc_note_t n;
        n = nt(1'b0);
        n.hash = {pd, 1'b1};
        if (op == 0) begin
            n.allow = p[7] ? (p[6] && sz) : !p[6];
            n.enc_chk = n.allow;
            n.enc = p[7];
        end else if (op == 1) begin
            if (p[14]) n.allow = sz && mac;
            else n.allow = (p[15:13] == 3'b000) && (sz || !p[7]);
        end else begin
            n.allow = p[13] && (!p[15] || mac);
            n.key_chk = n.allow;
            n.hash_chk = n.allow;
            n.key = p[12] ? p[11:8] : s;
        end
        return n;
    endfunction

    // ------------------------------------------------------------
    // Monitor: every new sequence number retires the oldest note.
    // ------------------------------------------------------------
    always @(posedge i_core_clk) begin
        if (!i_sys_rst && result.seq !== last_seq) begin
            last_seq = result.seq;
            if (notes.size() == 0) begin
                check("unexpected verdict", 32'h1, 32'h0);
            end else begin
                note = notes.pop_front();
                seen = note;
                seen.allow = result.allow;
                if (note.key_chk) seen.key = result.key_slot;
                if (note.hash_chk) seen.hash = result.hash_id;
                if (note.enc_chk) seen.enc = result.encrypt;
                check("verdict", 32'(seen), 32'(note));
                check("error", 32'(result.error), 32'(!note.allow));
                check("done", 32'(result.done), 32'h1);
            end
        end
    end

    // Watchdog: far beyond the 1,500 or so cycles the tests need at most.
    initial begin
        repeat (20000) @(posedge i_core_clk);
        bad_count++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(39));
        pol[0] = 16'h0000;
        pol[1] = 16'h6180;
        pol[2] = 16'hb5c3;
        pol[3] = 16'h2080;
        pol[4] = 16'h8080;
        for (int s = 5; s < NUM_SLOTS; s++) pol[s] = host_u.legal(16'($urandom));
        repeat (6) @(posedge i_core_clk);
        i_sys_rst <= 1'b0;
        rchk("data lock", ADDR_DATA_LOCK, 32'hff, {24'h0, LOCK_OPEN});
        rchk("config lock", ADDR_CFG_LOCK, 32'hff, {24'h0, LOCK_OPEN});
        rchk("otp policy", ADDR_OTP_POLICY, 32'hff, {24'h0, OTP_READ_ONLY});
        rchk("unmapped", 9'h010, 32'hffff_ffff, 32'h0);
        host_u.cycle(1'b1, ADDR_CFG_LOCK, 32'h0, rdata);
        rchk("lock by bus", ADDR_CFG_LOCK, 32'hff, {24'h0, LOCK_OPEN});
        $display("test registers done");
        for (int k = 0; k < 6; k++) req(EARLY[k], 4'(k), 1'b1, 1'b1, 7'h0, nt(1'b0));
        cfg_sweep(1'b1);
        for (int s = 0; s < NUM_SLOTS; s++) host_u.cycle(1'b1, ADDR_SLOT_BASE + 9'(4 * s),
            {16'h0, pol[s]}, rdata);
        rchk("slot policy", ADDR_SLOT_BASE + 9'h004, 32'hffff, {16'h0, pol[1]});
        $display("test config open done");
        req(4'h3, 4'h0, 1'b0, 1'b0, 7'h0, nt(1'b1));
        rchk("config locked", ADDR_CFG_LOCK, 32'hff, {24'h0, LOCK_SHUT});
        req(4'h3, 4'h0, 1'b0, 1'b0, 7'h0, nt(1'b0));
        host_u.cycle(1'b1, ADDR_SLOT_BASE, 32'h0000_ffff, rdata);
        rchk("frozen policy", ADDR_SLOT_BASE, 32'hffff, {16'h0, pol[0]});
        cfg_sweep(1'b0);
        $display("test config lock done");
        for (int s = 0; s < NUM_SLOTS; s++) begin
            req(4'h8, 4'(s), 1'($urandom), 1'b0, 7'h0, nt(1'b0));
            req(4'h9, 4'(s), 1'($urandom), 1'b0, 7'h0, nt(1'b1));
        end
        req(4'h5, 4'h0, 1'b1, 1'b0, 7'h0, nt(1'b1));
        req(4'h4, 4'h0, 1'b1, 1'b0, 7'h0, nt(1'b0));
        req(4'ha, 4'h1, 1'b1, 1'b1, 7'h0, nt(1'b0));
        req(4'hb, 4'h0, 1'b0, 1'b0, 7'h0, nt(1'b1));
        rchk("data locked", ADDR_DATA_LOCK, 32'hff, {24'h0, LOCK_SHUT});
        req(4'hb, 4'h0, 1'b0, 1'b0, 7'h0, nt(1'b0));
        $display("test data open done");
        for (int s = 0; s < NUM_SLOTS; s++) begin
            for (int op = 0; op < 3; op++) begin
                for (int b = 0; b < 4; b++) begin
                    req({2'd2, 2'(op)}, 4'(s), b[0], b[1], 7'h0,
                        exp_data(pol[s], 4'(s), op, b[0], b[1], 1'($urandom)));
                end
            end
        end
        $display("test slot policies done");
        req(4'h4, 4'h0, 1'b0, 1'b0, 7'h0, nt(1'b1));
        req(4'h4, 4'h0, 1'b1, 1'b0, 7'h0, nt(1'b1));
        req(4'h5, 4'h0, 1'b1, 1'b1, 7'h0, nt(1'b0));
        repeat (10) @(posedge i_core_clk);
        check("pending notes", 32'(notes.size()), 32'h0);
        rchk("deny count", ADDR_DENY_CNT, 32'hffff, 32'(denies));
        $display("test otp read only done");
        end_of_test();
    end
endmodule

`default_nettype wire
